// [design/ddw_pkg.sv]
package ddw_pkg;

  // register map, byte addresses on the apb slave
  localparam logic [11:0] OFS_CTRL   = 12'h000;
  localparam logic [11:0] OFS_CHEN   = 12'h004;
  localparam logic [11:0] OFS_MODE   = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  localparam logic [11:0] OFS_PTR    = 12'h040;

  // status word field positions
  localparam int STS_BUSY      = 0;
  localparam int STS_ERR       = 1;
  localparam int STS_ACT_LSB   = 4;
  localparam int STS_STATE_LSB = 8;
  localparam int STS_PEND_LSB  = 16;

  // descriptor control word (word 0) field positions
  localparam int DSC_ELEM_LSB  = 0;
  localparam int DSC_SRC_WIDE  = 2;
  localparam int DSC_DST_WIDE  = 3;
  localparam int DSC_HALT      = 4;
  localparam int DSC_COUNT_LSB = 16;

  // descriptor word indices
  localparam logic [1:0] DW_CTRL = 2'h0;
  localparam logic [1:0] DW_SRC  = 2'h1;
  localparam logic [1:0] DW_DST  = 2'h2;
  localparam logic [1:0] DW_NEXT = 2'h3;

  // element width codes
  localparam logic [1:0] ELEM_8  = 2'h0;
  localparam logic [1:0] ELEM_16 = 2'h1;
  localparam logic [1:0] ELEM_32 = 2'h2;

  // ahb-lite encodings
  localparam logic [1:0] HTRANS_IDLE   = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_BYTE    = 3'h0;
  localparam logic [2:0] HSIZE_HALF    = 3'h1;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_READ,
    ST_WRITE,
    ST_DONE
  } ddw_state_type;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } ddw_apb_req_type;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } ddw_apb_rsp_type;

  typedef struct packed {
    logic [1:0]  htrans;
    logic [31:0] haddr;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
  } ddw_ahb_out_type;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hready;
    logic        hresp;
  } ddw_ahb_in_type;

endpackage

// [design/ddw_width_conv.sv]
`timescale 1ns/10ps
module ddw_width_conv (
  input  wire logic [1:0]  elemW,    // element width code
  input  wire logic        srcWide,  // source access is a full word
  input  wire logic        dstWide,  // destination access is a full word
  input  wire logic [31:0] rdata,    // fetched bus word
  input  wire logic [1:0]  rdLo,     // source address low bits
  input  wire logic [31:0] elemIn,   // held element, low aligned
  input  wire logic [1:0]  wrLo,     // destination address low bits
  output logic      [31:0] elemOut,  // fetched element, low aligned
  output logic      [31:0] wdata     // word to drive on the write lanes
);
  import ddw_pkg::*;

  logic [31:0] mask;
  logic [31:0] shifted;

  always_comb begin
    case (elemW)
      ELEM_8:  mask = 32'h0000_00FF;
      ELEM_16: mask = 32'h0000_FFFF;
      default: mask = 32'hFFFF_FFFF;
    endcase
    // a narrow access carries its data on the lane chosen by the address
    shifted = srcWide ? rdata : (rdata >> {rdLo, 3'b000});
    elemOut = shifted & mask;
    // full-word destination: element low, upper bits zero
    wdata   = dstWide ? (elemIn & mask) : ((elemIn & mask) << {wrLo, 3'b000});
  end

endmodule // ddw_width_conv

// [design/ddw_dma_ctrl.sv]
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/10ps
// Contract
// - element width selects 32, 16 or 8 bits
// - each access width is element or 32 bits
// - 8-bit from word read drops upper 24
// - 8-bit to word write zero-pads upper 24
// - 16-bit from word read drops upper 16
// - 16-bit to word write zero-pads upper 16
// - finished descriptor continues at chain link pointer
// - zero chain link pointer ends the chain
// - looped chains run until error or disable
// - activated triggers recorded in per-channel pending bits
// - level triggers need no local pending storage
// - pulse triggers are latched until serviced
// - priority decoder picks highest priority pending channel
// - engine takes new channel only when idle
// - engine fetches descriptor before moving data
// - all bus traffic through one ahb-lite master
// - cpu reaches control and status registers
// - halt_after_descriptor disables channel; disabled ignores triggers
module ddw_dma_ctrl #(
  parameter int NCH = 4                          // channel count, 2..8
) (
  input  wire logic                     ref_clk, // system clock
  input  wire logic                     nrst,    // async reset, active low
  input  wire ddw_pkg::ddw_apb_req_type apbReq,  // apb request from cpu
  output var  ddw_pkg::ddw_apb_rsp_type apbRsp,  // apb answer
  input  wire ddw_pkg::ddw_ahb_in_type  ahbIn,   // ahb-lite master inputs
  output var  ddw_pkg::ddw_ahb_out_type ahbOut,  // ahb-lite master outputs
  input  wire logic [NCH-1:0]           trigIn   // channel triggers
);
  import ddw_pkg::*;

  localparam int CW = $clog2(NCH);

  typedef struct packed {
    ddw_state_type          state;
    logic                   dataPh;
    ddw_ahb_out_type        ahb;
    ddw_apb_rsp_type        apb;
    logic                   ctrlEn;
    logic                   err;
    logic [NCH-1:0]         chEn;
    logic [NCH-1:0]         pulseMode;
    logic [NCH-1:0]         pend;
    logic [NCH-1:0]         trigPrev;
    logic [NCH-1:0][31:0]   ptr;
    logic [CW-1:0]          act;
    logic [1:0]             fetchIdx;
    logic [31:0]            descCtrl;
    logic [31:0]            srcAddr;
    logic [31:0]            dstAddr;
    logic [31:0]            nextPtr;
    logic [31:0]            elem;
    logic [15:0]            remain;
  } ddw_regs_type;

  ddw_regs_type s;
  ddw_regs_type n;

  logic [NCH-1:0] req;
  logic           anyReq;
  logic [CW-1:0]  win;
  logic [1:0]     elemW;
  logic           srcWide;
  logic           dstWide;
  logic [2:0]     elemSize;
  logic [31:0]    elemStep;
  logic [31:0]    accAddr;
  logic           accWrite;
  logic [2:0]     accSize;
  logic           accDone;
  logic           accErr;
  logic [31:0]    convElem;
  logic [31:0]    convWdata;
  logic           ptrHit;
  logic [CW-1:0]  ptrIdx;
  logic [31:0]    rdWord;
  logic [NCH-1:0] rise;

  assign apbRsp = s.apb;
  assign ahbOut = s.ahb;

  ////////////////////////////////////////////////////////////////////////////
  // descriptor decode and width conversion

  assign elemW   = s.descCtrl[DSC_ELEM_LSB +: 2];
  assign srcWide = s.descCtrl[DSC_SRC_WIDE] | (elemW == ELEM_32);
  assign dstWide = s.descCtrl[DSC_DST_WIDE] | (elemW == ELEM_32);

  always_comb begin
    case (elemW)
      ELEM_8:  begin elemSize = HSIZE_BYTE; elemStep = 32'h0000_0001; end
      ELEM_16: begin elemSize = HSIZE_HALF; elemStep = 32'h0000_0002; end
      default: begin elemSize = HSIZE_WORD; elemStep = 32'h0000_0004; end
    endcase
  end

  ddw_width_conv u_conv (
    .elemW   (elemW),
    .srcWide (srcWide),
    .dstWide (dstWide),
    .rdata   (ahbIn.hrdata),
    .rdLo    (s.srcAddr[1:0]),
    .elemIn  (s.elem),
    .wrLo    (s.dstAddr[1:0]),
    .elemOut (convElem),
    .wdata   (convWdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  // requests and priority

  always_comb begin
    anyReq = 1'b0;
    win    = '0;
    for (int i = 0; i < NCH; i++) begin
      // level triggers are used as they stand, pulses through the latch
      req[i]  = s.chEn[i] & (s.pulseMode[i] ? s.pend[i] : trigIn[i]);
      rise[i] = trigIn[i] & ~s.trigPrev[i];
    end
    // lowest index has highest priority
    for (int i = NCH - 1; i >= 0; i--) begin
      if (req[i]) begin
        anyReq = 1'b1;
        win    = CW'(i);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus access selection

  always_comb begin
    accAddr  = s.srcAddr;
    accWrite = 1'b0;
    accSize  = HSIZE_WORD;
    case (s.state)
      ST_FETCH: accAddr = s.ptr[s.act] + {28'h000_0000, s.fetchIdx, 2'b00};
      ST_READ:  accSize = srcWide ? HSIZE_WORD : elemSize;
      ST_WRITE: begin
        accAddr  = s.dstAddr;
        accWrite = 1'b1;
        accSize  = dstWide ? HSIZE_WORD : elemSize;
      end
      default: accAddr = s.srcAddr;
    endcase
  end

  assign ptrHit = (apbReq.paddr >= OFS_PTR) && (apbReq.paddr < OFS_PTR + 12'(4 * NCH));
  assign ptrIdx = CW'((apbReq.paddr - OFS_PTR) >> 2);

  always_comb begin
    rdWord = 32'h0000_0000;
    rdWord[STS_BUSY] = (s.state != ST_IDLE);
    rdWord[STS_ERR] = s.err;
    rdWord[STS_ACT_LSB +: CW] = s.act;
    rdWord[STS_STATE_LSB +: 3] = s.state;
    rdWord[STS_PEND_LSB +: NCH] = s.pend;
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    n = s;
    accDone = 1'b0;
    accErr  = 1'b0;

    // apb slave, one wait cycle then pready for a single cycle
    n.apb.pready  = 1'b0;
    n.apb.pslverr = 1'b0;
    if (apbReq.psel && apbReq.penable && !s.apb.pready) begin
      n.apb.pready = 1'b1;
      n.apb.prdata = 32'h0000_0000;
      if (apbReq.paddr == OFS_CTRL) begin
        n.apb.prdata[0] = s.ctrlEn;
        if (apbReq.pwrite) n.ctrlEn = apbReq.pwdata[0];
      end else if (apbReq.paddr == OFS_CHEN) begin
        n.apb.prdata[NCH-1:0] = s.chEn;
        if (apbReq.pwrite) n.chEn = apbReq.pwdata[NCH-1:0];
      end else if (apbReq.paddr == OFS_MODE) begin
        n.apb.prdata[NCH-1:0] = s.pulseMode;
        if (apbReq.pwrite) n.pulseMode = apbReq.pwdata[NCH-1:0];
      end else if (apbReq.paddr == OFS_STATUS) begin
        n.apb.prdata = rdWord;
        if (apbReq.pwrite && apbReq.pwdata[STS_ERR]) n.err = 1'b0;
      end else if (ptrHit) begin
        n.apb.prdata = s.ptr[ptrIdx];
        if (apbReq.pwrite) n.ptr[ptrIdx] = apbReq.pwdata;
      end else begin
        n.apb.pslverr = 1'b1;
      end
    end

    // single outstanding ahb transfer: address phase, then data phase
    if (s.state == ST_FETCH || s.state == ST_READ || s.state == ST_WRITE) begin
      if (!s.dataPh && s.ahb.htrans == HTRANS_IDLE) begin
        n.ahb.htrans = HTRANS_NONSEQ;
        n.ahb.haddr  = accAddr;
        n.ahb.hwrite = accWrite;
        n.ahb.hsize  = accSize;
      end else if (s.ahb.htrans == HTRANS_NONSEQ && ahbIn.hready) begin
        n.ahb.htrans = HTRANS_IDLE;
        n.ahb.hwdata = convWdata;
        n.dataPh     = 1'b1;
      end else if (s.dataPh && ahbIn.hready) begin
        n.dataPh = 1'b0;
        accDone  = 1'b1;
        accErr   = ahbIn.hresp;
      end
    end

    case (s.state)
      ST_IDLE: begin
        if (s.ctrlEn && anyReq) begin
          n.act       = win;
          n.pend[win] = 1'b0;
          n.fetchIdx  = 2'h0;
          n.state     = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (accDone) begin
          case (s.fetchIdx)
            DW_CTRL: n.descCtrl = ahbIn.hrdata;
            DW_SRC:  n.srcAddr  = ahbIn.hrdata;
            DW_DST:  n.dstAddr  = ahbIn.hrdata;
            default: n.nextPtr  = ahbIn.hrdata;
          endcase
          n.remain   = (s.fetchIdx == DW_CTRL) ? ahbIn.hrdata[DSC_COUNT_LSB +: 16] : s.remain;
          n.fetchIdx = s.fetchIdx + 2'h1;
          if (s.fetchIdx == DW_NEXT) n.state = ST_READ;
        end
      end
      ST_READ: begin
        if (accDone) begin
          n.elem  = convElem;
          n.state = ST_WRITE;
        end
      end
      ST_WRITE: begin
        if (accDone) begin
          n.srcAddr = s.srcAddr + (srcWide ? 32'h0000_0004 : elemStep);
          n.dstAddr = s.dstAddr + (dstWide ? 32'h0000_0004 : elemStep);
          n.remain  = s.remain - 16'h0001;
          n.state   = (s.remain == 16'h0000) ? ST_DONE : ST_READ;
        end
      end
      ST_DONE: begin
        n.state = ST_IDLE;
        if (s.nextPtr != 32'h0000_0000) n.ptr[s.act] = s.nextPtr;
        if (s.descCtrl[DSC_HALT]) begin
          n.chEn[s.act] = 1'b0;
        end else if (s.nextPtr != 32'h0000_0000 && s.ctrlEn && s.chEn[s.act]) begin
          // loops keep going; only error, disable or a halt descriptor stops them
          n.fetchIdx = 2'h0;
          n.state    = ST_FETCH;
        end
      end
      default: n.state = ST_IDLE;
    endcase

    // a bus error ends the channel and leaves a sticky flag
    if (accErr) begin
      n.err         = 1'b1;
      n.chEn[s.act] = 1'b0;
      n.state       = ST_IDLE;
    end

    // pulse latch; a new edge beats the clear on the take
    for (int i = 0; i < NCH; i++) begin
      n.trigPrev[i] = trigIn[i];
      if (!s.chEn[i]) begin
        n.pend[i] = 1'b0;
      end else if (s.pulseMode[i] && rise[i]) begin
        n.pend[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  logic [31:0] wrElem;
  assign wrElem = s.elem;

  fetch_is_word_a: assert property ((s.state == ST_FETCH && s.ahb.htrans == HTRANS_NONSEQ)
    |-> (s.ahb.hsize == HSIZE_WORD && !s.ahb.hwrite))
    else $error("descriptor fetch not a word read");
  pad_byte_a: assert property ((s.dataPh && s.state == ST_WRITE && elemW == ELEM_8 && dstWide)
    |-> (s.ahb.hwdata == {24'h00_0000, wrElem[7:0]}))
    else $error("byte element not zero padded");
  pad_half_a: assert property ((s.dataPh && s.state == ST_WRITE && elemW == ELEM_16 && dstWide)
    |-> (s.ahb.hwdata == {16'h0000, wrElem[15:0]}))
    else $error("half element not zero padded");
  drop_byte_a: assert property ((accDone && s.state == ST_READ && elemW == ELEM_8 && srcWide)
    |=> (s.elem == {24'h00_0000, $past(ahbIn.hrdata[7:0])}))
    else $error("byte element upper bits kept");
  drop_half_a: assert property ((accDone && s.state == ST_READ && elemW == ELEM_16 && srcWide)
    |=> (s.elem == {16'h0000, $past(ahbIn.hrdata[15:0])}))
    else $error("half element upper bits kept");
  halt_disables_a: assert property ((s.state == ST_DONE && s.descCtrl[DSC_HALT])
    |=> (s.state == ST_IDLE && !s.chEn[$past(s.act)]))
    else $error("halt did not disable channel");
  chain_end_a: assert property ((s.state == ST_DONE && s.nextPtr == 32'h0000_0000)
    |=> (s.state == ST_IDLE))
    else $error("fetch after null chain link");
  chain_next_a: assert property ((s.state == ST_DONE && s.nextPtr != 32'h0000_0000
    && !s.descCtrl[DSC_HALT] && s.ctrlEn && s.chEn[s.act])
    |=> (s.state == ST_FETCH && s.ptr[s.act] == $past(s.nextPtr)))
    else $error("chain link not followed");
  take_winner_a: assert property ((s.state == ST_IDLE && s.ctrlEn && anyReq)
    |=> (s.state == ST_FETCH && s.act == $past(win)))
    else $error("wrong channel taken");
  busy_no_take_a: assert property ((s.state != ST_IDLE && s.state != ST_DONE && !accErr)
    |=> $stable(s.act))
    else $error("channel changed while busy");
  apb_answer_a: assert property ((apbReq.psel && apbReq.penable && !s.apb.pready)
    |=> (s.apb.pready ##1 !s.apb.pready))
    else $error("apb answer not one cycle");
  pulse_latch_a: assert property ((s.chEn[0] && s.pulseMode[0] && rise[0])
    |=> s.pend[0])
    else $error("pulse trigger lost");

  chain_c:  cover property (s.state == ST_DONE ##1 s.state == ST_FETCH);
  pad_c:    cover property (s.dataPh && s.state == ST_WRITE && elemW == ELEM_8 && dstWide);
  halt_c:   cover property (s.state == ST_DONE && s.descCtrl[DSC_HALT]);
  buserr_c: cover property (accErr);

endmodule // ddw_dma_ctrl

// [tb/ddw_ahb_mem.sv]
`timescale 1ns/10ps
module ddw_ahb_mem (
  input  wire logic                     ref_clk, // system clock
  input  wire logic                     nrst,    // async reset, active low
  input  wire ddw_pkg::ddw_ahb_out_type ahbOut,  // master request
  output var  ddw_pkg::ddw_ahb_in_type  ahbIn,   // slave answer
  input  wire logic [1:0]               maxWait, // longest stall per transfer
  input  wire logic                     errOn    // answer every transfer with an error
);
  import ddw_pkg::*;
  logic [31:0] mem [0:1023];
  logic        dPh;
  logic        dWr;
  logic [11:0] dAdr;
  logic [2:0]  dSz;
  logic [1:0]  waitCnt;
  logic [31:0] junk;
  logic [31:0] merged;

  // narrow writes touch only their own lanes
  always_comb begin
    merged = mem[dAdr[11:2]];
    if (dSz == HSIZE_BYTE) begin
      merged[8*dAdr[1:0] +: 8] = ahbOut.hwdata[8*dAdr[1:0] +: 8];
    end else if (dSz == HSIZE_HALF) begin
      merged[16*dAdr[1] +: 16] = ahbOut.hwdata[16*dAdr[1] +: 16];
    end else begin
      merged = ahbOut.hwdata;
    end
  end

  assign ahbIn.hready = !dPh || waitCnt == 2'h0;
  // two-cycle error: stalled first cycle, then ready, hresp high in both
  assign ahbIn.hresp  = errOn && dPh;
  // lanes carry a moving pattern except on a released read data phase, never the last word
  assign ahbIn.hrdata = (dPh && !dWr && ahbIn.hready) ? mem[dAdr[11:2]] : junk;

  // plain always: the bench preloads mem by backdoor
  always @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      dPh     <= 1'b0;
      dWr     <= 1'b0;
      dAdr    <= 12'h000;
      dSz     <= 3'h0;
      waitCnt <= 2'h0;
      junk    <= 32'h5A5A_0001;
    end else begin
      junk <= {junk[30:0], junk[31] ^ junk[21] ^ junk[1] ^ junk[0]};
      if (dPh && ahbIn.hready) begin
        dPh <= 1'b0;
        if (dWr) mem[dAdr[11:2]] <= merged;
      end
      if (ahbIn.hready && ahbOut.htrans == HTRANS_NONSEQ) begin
        dPh     <= 1'b1;
        dWr     <= ahbOut.hwrite;
        dAdr    <= ahbOut.haddr[11:0];
        dSz     <= ahbOut.hsize;
        waitCnt <= errOn ? 2'h1 : 2'($urandom_range(32'(maxWait)));
      end else if (dPh && waitCnt != 2'h0) begin
        waitCnt <= waitCnt - 2'h1;
      end
    end
  end
endmodule // ddw_ahb_mem

// [tb/ddw_dma_ctrl_tb_top.sv]
`timescale 1ns/10ps
module ddw_dma_ctrl_tb_top;
  import ddw_pkg::*;
  logic            ref_clk;
  logic            nrst;
  ddw_apb_req_type apbReq;
  ddw_apb_rsp_type apbRsp;
  ddw_ahb_in_type  ahbIn;
  ddw_ahb_out_type ahbOut;
  logic [3:0]      trigIn;
  logic [1:0]      maxWait;
  logic            errOn;
  logic [31:0]     rd;
  logic            se;
  int              err_total;
  int              checked;

  ddw_dma_ctrl #(.NCH(4)) ddw_dma_ctrl_i (.ref_clk(ref_clk), .nrst(nrst), .apbReq(apbReq), .apbRsp(apbRsp),
                                          .ahbIn(ahbIn), .ahbOut(ahbOut), .trigIn(trigIn));
  ddw_ahb_mem ddw_ahb_mem_i (.ref_clk(ref_clk), .nrst(nrst), .ahbOut(ahbOut), .ahbIn(ahbIn), .maxWait(maxWait),
                             .errOn(errOn));

  always #20 ref_clk = ~ref_clk;

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // entered and left just after a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge ref_clk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 50);
    rd = apbRsp.prdata;
    se = apbRsp.pslverr;
    if (n >= 50) chk(32'h0000_0000, 32'h0000_0001, "apb answer missing");
    apbReq <= '0;
    @(posedge ref_clk);
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 32'h0000_0000);
      n++;
    end while ((rd[STS_BUSY] !== 1'b0 || rd[STS_PEND_LSB +: 4] !== 4'h0) && n < 300);
    chk({31'h0, rd[STS_BUSY]}, 32'h0000_0000, "engine never idle");
  endtask

  // pulse sources hold two cycles; level ones hold until the fetch starts
  task automatic fire(input logic [3:0] m, input logic lvl);
    trigIn <= m;
    repeat (2) @(posedge ref_clk);
    for (int n = 0; lvl && n < 20 && ahbOut.htrans !== HTRANS_NONSEQ; n++) @(posedge ref_clk);
    trigIn <= 4'h0;
    @(posedge ref_clk);
  endtask

  task automatic desc(input int a, input logic [1:0] e, input logic sw, input logic dw, input logic h,
                      input logic [15:0] cm1, input int s, input int d, input int nx);
    ddw_ahb_mem_i.mem[a/4]   = {cm1, 11'h000, h, dw, sw, e};
    ddw_ahb_mem_i.mem[a/4+1] = s;
    ddw_ahb_mem_i.mem[a/4+2] = d;
    ddw_ahb_mem_i.mem[a/4+3] = nx;
  endtask

  function automatic logic [31:0] elem_at(input int a, input int eb);
    logic [31:0] v;
    v = '0;
    for (int k = 0; k < eb; k++) v[8*k +: 8] = ddw_ahb_mem_i.mem[(a+k)/4][8*((a+k)%4) +: 8];
    return v;
  endfunction

  task automatic check_move(input int s, input int d, input int eb, input int cnt, input logic sw, input logic dw);
    logic [31:0] v;
    logic [31:0] msk;
    msk = (eb == 4) ? 32'hFFFF_FFFF : (32'h0000_0001 << (8*eb)) - 32'h0000_0001;
    for (int i = 0; i < cnt; i++) begin
      v = sw ? (elem_at(s+4*i, 4) & msk) : elem_at(s+eb*i, eb);
      if (dw) chk(elem_at(d+4*i, 4), v, "padded word");
      else chk(elem_at(d+eb*i, eb), v, "narrow element");
    end
  endtask

  task automatic fill();
    for (int i = 0; i < 32; i++) begin
      ddw_ahb_mem_i.mem[256+i] = $urandom;
      ddw_ahb_mem_i.mem[512+i] = $urandom;
    end
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    int   ch;
    int   cnt;
    int   eb;
    int   s;
    int   d;
    logic sw;
    logic dw;
    ref_clk = 1'b0;
    nrst = 1'b0;
    apbReq = '0;
    trigIn = 4'h0;
    maxWait = 2'h0;
    errOn = 1'b0;
    err_total = 0;
    checked = 0;
    void'($urandom(22012));
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    @(posedge ref_clk);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "status after reset");
    apb(1'b1, 12'h010, 32'hFFFF_FFFF);
    chk({31'h0, se}, 32'h0000_0001, "unmapped write");
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    apb(1'b1, OFS_CHEN, 32'h0000_000F);
    apb(1'b1, OFS_MODE, 32'h0000_0007);
    $display("test reset_map done");
    // every width combination, random channel, count and stalls
    for (int e = 0; e < 3; e++) begin
      for (int w = 0; w < 4; w++) begin
        if (e == 2 && w != 3) continue;
        sw = w[0];
        dw = w[1];
        eb = 1 << e;
        ch = $urandom_range(2);
        cnt = $urandom_range(3, 1);
        maxWait <= 2'($urandom_range(2));
        s = 32'h0000_0400 + (sw ? 0 : eb);
        d = 32'h0000_0800 + (dw ? 0 : eb);
        fill();
        desc(0, 2'(e), sw, dw, 1'b0, 16'(cnt-1), s, d, 0);
        apb(1'b1, 12'(OFS_PTR + 4*ch), 32'h0000_0000);
        fire(4'(1 << ch), 1'b0);
        wait_idle();
        check_move(s, d, eb, cnt, sw, dw);
      end
    end
    $display("test widths done");
    fill();
    desc(12'h000, ELEM_8, 1'b1, 1'b1, 1'b0, 16'h0001, 12'h400, 12'h800, 12'h010);
    desc(12'h010, ELEM_16, 1'b0, 1'b1, 1'b0, 16'h0000, 12'h422, 12'h840, 0);
    apb(1'b1, 12'(OFS_PTR + 12), 32'h0000_0000);
    fire(4'h8, 1'b1);
    wait_idle();
    check_move(12'h400, 12'h800, 1, 2, 1'b1, 1'b1);
    check_move(12'h422, 12'h840, 2, 1, 1'b0, 1'b1);
    apb(1'b0, 12'(OFS_PTR + 12), 32'h0000_0000);
    chk(rd, 32'h0000_0010, "pointer at last descriptor");
    $display("test chain done");
    // both fire together: lower index runs first, so the higher one lands last
    desc(12'h020, ELEM_32, 1'b1, 1'b1, 1'b0, 16'h0000, 12'h400, 12'h880, 0);
    desc(12'h030, ELEM_32, 1'b1, 1'b1, 1'b0, 16'h0000, 12'h404, 12'h880, 0);
    apb(1'b1, 12'(OFS_PTR + 4), 32'h0000_0020);
    apb(1'b1, 12'(OFS_PTR + 8), 32'h0000_0030);
    fire(4'h6, 1'b0);
    wait_idle();
    chk(ddw_ahb_mem_i.mem[12'h880/4], ddw_ahb_mem_i.mem[12'h404/4], "priority order");
    $display("test priority done");
    desc(12'h040, ELEM_8, 1'b1, 1'b1, 1'b1, 16'h0000, 12'h400, 12'h800, 12'h050);
    apb(1'b1, OFS_PTR, 32'h0000_0040);
    fire(4'h1, 1'b0);
    wait_idle();
    apb(1'b0, OFS_CHEN, 32'h0000_0000);
    chk({28'h0, rd[3:0]}, 32'h0000_000E, "halt clears enable");
    apb(1'b0, OFS_PTR, 32'h0000_0000);
    chk(rd, 32'h0000_0050, "link loaded on halt");
    fire(4'h1, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h000F_0001, 32'h0000_0000, "disabled channel ignores trigger");
    $display("test halt done");
    desc(12'h060, ELEM_32, 1'b1, 1'b1, 1'b0, 16'h0000, 12'h400, 12'h800, 12'h070);
    desc(12'h070, ELEM_32, 1'b1, 1'b1, 1'b0, 16'h0000, 12'h404, 12'h804, 12'h060);
    apb(1'b1, 12'(OFS_PTR + 4), 32'h0000_0060);
    fire(4'h2, 1'b0);
    repeat (200) @(posedge ref_clk);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk({31'h0, rd[STS_BUSY]}, 32'h0000_0001, "loop keeps running");
    apb(1'b1, OFS_CHEN, 32'h0000_000C);
    wait_idle();
    chk({31'h0, rd[STS_BUSY]}, 32'h0000_0000, "loop stops on disable");
    $display("test loop done");
    // every access answered with an error: sticky flag, channel dropped, engine idle
    errOn <= 1'b1;
    fire(4'h4, 1'b0);
    wait_idle();
    chk(rd & 32'h0000_0003, 32'h0000_0002, "bus error flagged");
    errOn <= 1'b0;
    apb(1'b0, OFS_CHEN, 32'h0000_0000);
    chk({28'h0, rd[3:0]}, 32'h0000_0008, "bus error drops channel");
    apb(1'b1, OFS_STATUS, 32'h0000_0002);
    apb(1'b0, OFS_STATUS, 32'h0000_0000);
    chk(rd & 32'h0000_0002, 32'h0000_0000, "error flag cleared");
    $display("test buserr done");
    finish_test();
  end

  initial begin
    repeat (40000) @(posedge ref_clk);
    err_total++;
    finish_test();
  end
endmodule // ddw_dma_ctrl_tb_top
